// *** bcs_pkg.sv ***
package bcs_pkg;

  // operation select from the decoder, one-hot codes written out
  typedef enum logic [4:0] {
    BCS_OP_NONE    = 5'h00,
    BCS_OP_BRANCH  = 5'h01,
    BCS_OP_SHIFT   = 5'h02
  } bcs_class_e;

  // branch condition codes
  localparam logic [3:0] COND_UNSIGNED_GE = 4'h0;
  localparam logic [3:0] COND_UNSIGNED_LT = 4'h1;
  localparam logic [3:0] COND_NEGATIVE = 4'h2;
  localparam logic [3:0] COND_NONNEGATIVE = 4'h3;
  localparam logic [3:0] COND_SIGNED_GE = 4'h4;
  localparam logic [3:0] COND_SIGNED_LT = 4'h5;
  localparam logic [3:0] COND_HALF_SET = 4'h6;
  localparam logic [3:0] COND_HALF_CLEAR = 4'h7;
  localparam logic [3:0] COND_TBIT_SET = 4'h8;
  localparam logic [3:0] COND_TBIT_CLEAR = 4'h9;
  localparam logic [3:0] COND_OVF_SET = 4'hA;
  localparam logic [3:0] COND_OVF_CLEAR = 4'hB;
  localparam logic [3:0] COND_IRQ_ENABLED = 4'hC;
  localparam logic [3:0] COND_IRQ_DISABLED = 4'hD;

  // single register operation codes
  localparam logic [2:0] SOP_SHIFT_LEFT_LOGICAL = 3'h0;
  localparam logic [2:0] SOP_SHIFT_RIGHT_LOGICAL = 3'h1;
  localparam logic [2:0] SOP_ROTATE_LEFT_CARRY = 3'h2;
  localparam logic [2:0] SOP_ROTATE_RIGHT_CARRY = 3'h3;
  localparam logic [2:0] SOP_SHIFT_RIGHT_ARITH = 3'h4;
  localparam logic [2:0] SOP_SWAP_NIBBLES = 3'h5;

  // status flag bit positions
  localparam int FLAG_C = 0;
  localparam int FLAG_Z = 1;
  localparam int FLAG_N = 2;
  localparam int FLAG_V = 3;
  localparam int FLAG_S = 4;
  localparam int FLAG_H = 5;
  localparam int FLAG_T = 6;
  localparam int FLAG_I = 7;

  localparam int PC_W = 16;
  localparam logic [PC_W-1:0] PC_RESET = 16'h0000;
  localparam logic [7:0] FLAGS_RESET = 8'h00;
  localparam logic [7:0] DATA_RESET = 8'h00;
  localparam logic [1:0] TAKEN_CYCLES = 2'h2;

  // decoded instruction as it arrives from the decoder
  typedef struct packed {
    logic valid;
    logic isBranch;
    logic [3:0] cond;
    logic [2:0] sop;
    logic [6:0] offset;
    logic [PC_W-1:0] pc;
    logic [7:0] rd;
  } bcs_instr_s;

  // result handed back to pc, register file and status register
  typedef struct packed {
    logic pcLoad;
    logic [PC_W-1:0] pcTarget;
    logic flush;
    logic rdWrite;
    logic [7:0] rdValue;
    logic flagWrite;
    logic [7:0] flagsNew;
  } bcs_result_s;

endpackage

// *** bcs_shift_unit.sv ***
`timescale 1ns/1ps
`default_nettype none
// combinational shift, rotate and swap core with flag results
module bcs_shift_unit
  import bcs_pkg::*;
(
  input wire logic [2:0] sop,
  input wire logic [7:0] rd,
  input wire logic [7:0] flagsIn,
  output logic [7:0] result,
  output logic [7:0] flagsOut,
  output logic changesFlags
);

  // value and carry out per operation, flags derived afterwards
  always_comb begin
    logic [7:0] r;
    logic c;
    logic n;
    logic v;
    r = rd;
    n = 1'b0;
    v = 1'b0;
    c = flagsIn[FLAG_C];
    flagsOut = flagsIn;
    changesFlags = 1'b1;
    case (sop)
      SOP_SHIFT_LEFT_LOGICAL: begin
        r = {rd[6:0], 1'b0};
        c = rd[7];
        flagsOut[FLAG_H] = rd[3];
      end
      SOP_SHIFT_RIGHT_LOGICAL: begin
        r = {1'b0, rd[7:1]};
        c = rd[0];
      end
      SOP_ROTATE_LEFT_CARRY: begin
        r = {rd[6:0], flagsIn[FLAG_C]};
        c = rd[7];
        flagsOut[FLAG_H] = rd[3];
      end
      SOP_ROTATE_RIGHT_CARRY: begin
        r = {flagsIn[FLAG_C], rd[7:1]};
        c = rd[0];
      end
      SOP_SHIFT_RIGHT_ARITH: begin
        r = {rd[7], rd[7:1]};
        c = rd[0];
      end
      SOP_SWAP_NIBBLES: begin
        r = {rd[3:0], rd[7:4]};
        changesFlags = 1'b0;
      end
      default: begin
        changesFlags = 1'b0;
      end
    endcase
    // overflow is n xor c for every shift form here
    n = r[7];
    v = n ^ c;
    if (changesFlags) begin
      flagsOut[FLAG_C] = c;
      flagsOut[FLAG_Z] = (r == 8'h00);
      flagsOut[FLAG_N] = n;
      flagsOut[FLAG_V] = v;
      flagsOut[FLAG_S] = n ^ v;
    end
    result = r;
  end

endmodule // bcs_shift_unit
`default_nettype wire

// *** bcs_branch_shift.sv ***
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - unsigned branches test carry, target pc+k+1
// - sign branches test negative, flags untouched
// - signed branches test negative xor overflow
// - half-carry branches test half-carry flag
// - transfer-bit branches test stored t flag
// - overflow branches test overflow, flags untouched
// - interrupt branches test global enable flag
// - shift left logical, clear bit0, flags
// - shift right logical, clear bit7, flags
// - rotate left: old carry into bit0
// - rotate right: old carry into bit7
// - arithmetic shift: bits 0-6 from above
// - nibble swap, single cycle, no flags
////////////////////////////////////////////////////////////////////
// how the unit sits in the core
// - the decoder offers one instruction a cycle on instr, qualified by valid
// - an instruction is taken on a rising edge with valid high and busy low
// - pcLoad, flush, rdWrite and flagWrite rise at the taking edge and show in the cycle after it, as one-cycle pulses
// - pcTarget, rdValue and flagsNew hold until the next instruction updates them
// - a taken branch raises pcLoad and flush together, then busy blocks
//   the word fetched behind it, which the unit ignores in full
// - a branch reads flagsIn as it stands in its own cycle; a shift's flags
//   reach the status register one edge after the shift, so the decoder must
//   not issue a dependent branch in the cycle right behind the shift
// - undefined condition codes never branch and undefined shift codes hand
//   the operand back unchanged without touching the flags
// - nothing here is buffered: the unit keeps no copy of an instruction
//   beyond the cycle in which it is taken
// - reset is asynchronous; every output clears at once and the first
//   instruction may be offered at the first edge after release
////////////////////////////////////////////////////////////////////
module bcs_branch_shift
  import bcs_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire bcs_instr_s instr,
  input wire logic [7:0] flagsIn,
  output bcs_result_s result,
  output logic busy
);

  ////////////////////////////////////////////////////////////////////
  // condition decode, used for the branch decision
  // codes come in pairs, each pair testing one condition for both of its values,
  // so flipping the low code bit inverts the decision for codes 0 to 13
  // the signed pair is the only one built from two flags: a signed compare
  // has to see past an overflow of the subtraction that set them
  function automatic logic condMet(input logic [3:0] cond, input logic [7:0] f);
    case (cond)
      COND_UNSIGNED_GE: condMet = ~f[FLAG_C];
      COND_UNSIGNED_LT: condMet = f[FLAG_C];
      COND_NEGATIVE: condMet = f[FLAG_N];
      COND_NONNEGATIVE: condMet = ~f[FLAG_N];
      COND_SIGNED_GE: condMet = ~(f[FLAG_N] ^ f[FLAG_V]);
      COND_SIGNED_LT: condMet = f[FLAG_N] ^ f[FLAG_V];
      COND_HALF_SET: condMet = f[FLAG_H];
      COND_HALF_CLEAR: condMet = ~f[FLAG_H];
      COND_TBIT_SET: condMet = f[FLAG_T];
      COND_TBIT_CLEAR: condMet = ~f[FLAG_T];
      COND_OVF_SET: condMet = f[FLAG_V];
      COND_OVF_CLEAR: condMet = ~f[FLAG_V];
      COND_IRQ_ENABLED: condMet = f[FLAG_I];
      COND_IRQ_DISABLED: condMet = ~f[FLAG_I];
      default: condMet = 1'b0; // undefined codes never branch
    endcase
  endfunction

  // sign-extended relative target, shared by every branch form
  // the sum wraps at the top of the 16-bit space on purpose, as the program
  // counter does, so a backward jump from address 0 lands near the end
  function automatic logic [PC_W-1:0] relTarget(input logic [PC_W-1:0] pc,
                                                input logic [6:0] k);
    relTarget = pc + {{(PC_W-7){k[6]}}, k} + 16'h0001;
  endfunction

  ////////////////////////////////////////////////////////////////////
  // state machine: a taken branch owns a second cycle
  // idle takes a new instruction every cycle; taken lasts exactly one cycle
  // and refuses whatever is offered, which is the word fetched too early
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_TAKEN = 2'b10
  } bcs_state_e;

  bcs_state_e state_ff; // current state
  bcs_state_e nxt_state; // next state
  logic branchTaken; // branch request with condition met
  logic accept; // instruction accepted this cycle
  logic [7:0] shResult; // shift unit data
  logic [7:0] shFlags; // shift unit flags
  logic shFlagsChange; // shift unit writes status
  logic shiftAccept; // single-register operation taken this cycle
  logic shiftFlagWrite; // that operation also writes the status flags

  // the second cycle of a taken branch refuses new input
  assign accept = instr.valid && (state_ff == ST_IDLE);
  assign branchTaken = accept && instr.isBranch && condMet(instr.cond, flagsIn);

  // a taken shift, rotate or swap: the only thing that writes rd and flags
  assign shiftAccept = accept && !instr.isBranch;
  assign shiftFlagWrite = shiftAccept && shFlagsChange;

  // pure logic; it sees the operand in the cycle it is offered
  bcs_shift_unit bcs_shift_unit_i (
    .sop(instr.sop),
    .rd(instr.rd),
    .flagsIn(flagsIn),
    .result(shResult),
    .flagsOut(shFlags),
    .changesFlags(shFlagsChange)
  );

  // next state logic
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      ST_IDLE: begin
        // a false condition or a shift stays here: one cycle each
        if (branchTaken) begin
          nxt_state = ST_TAKEN;
        end
      end
      ST_TAKEN: begin
        // the discard cycle never lasts longer than one edge
        nxt_state = ST_IDLE;
      end
      default: begin
        // an illegal code falls back to idle rather than lock up
        nxt_state = ST_IDLE;
      end
    endcase
  end

  // state register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_ff <= ST_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // busy: stalls the decoder during the discard cycle
  // it mirrors the taken state, kept as its own flop so the port is registered
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      busy <= 1'b0;
    end else begin
      busy <= branchTaken;
    end
  end

  // redirect pulse: one cycle, only for a taken branch
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      result.pcLoad <= 1'b0;
    end else begin
      result.pcLoad <= branchTaken;
    end
  end

  // flush pulse: marks the already fetched word as discarded
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      result.flush <= 1'b0;
    end else begin
      result.flush <= branchTaken;
    end
  end

  // redirect target, held between branches
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      result.pcTarget <= PC_RESET;
    end else if (branchTaken) begin
      // not-taken branches and shifts leave the last target alone
      result.pcTarget <= relTarget(instr.pc, instr.offset);
    end
  end

  // register write pulse for every taken shift, rotate or swap
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      result.rdWrite <= 1'b0;
    end else begin
      result.rdWrite <= shiftAccept;
    end
  end

  // new register value, held until the next single-register operation
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      result.rdValue <= DATA_RESET;
    end else if (shiftAccept) begin
      result.rdValue <= shResult;
    end
  end

  // flag write pulse; branches and the swap never raise it
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      result.flagWrite <= 1'b0;
    end else begin
      result.flagWrite <= shiftFlagWrite;
    end
  end

  // full status image; flags an operation does not touch keep flagsIn, so
  // the status register can load all eight bits without a mask
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      result.flagsNew <= FLAGS_RESET;
    end else if (shiftAccept) begin
      result.flagsNew <= shFlags;
    end
  end

endmodule // bcs_branch_shift
`default_nettype wire

// *** bcs_branch_shift_assertions.sv ***
`timescale 1ns/1ps
`default_nettype none
// port watcher: branch pulse timing and shift results
module bcs_checker
  import bcs_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire bcs_instr_s instr,
  input wire logic [7:0] flagsIn,
  input wire bcs_result_s result,
  input wire logic busy
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  logic acc; // taken this edge
  logic shf; // shift taken
  assign acc = instr.valid && !busy;
  assign shf = acc && !instr.isBranch;
  a_taken_pair: assert property (result.pcLoad |-> result.flush && busy)
    else $error("taken without flush");
  a_busy_single: assert property (busy |=> !busy)
    else $error("busy too long");
  a_refused_quiet: assert property (busy |=> !result.rdWrite && !result.pcLoad)
    else $error("refused op acted");
  a_minus_taken: assert property (acc && instr.isBranch && instr.cond == COND_NEGATIVE
    |=> result.pcLoad == $past(flagsIn[FLAG_N])) else $error("minus branch wrong");
  a_branch_target: assert property (acc && instr.isBranch |=> !result.pcLoad ||
    result.pcTarget == $past(instr.pc) + {{9{$past(instr.offset[6])}}, $past(instr.offset)}
    + 16'h0001) else $error("branch target wrong");
  a_branch_noflag: assert property (acc && instr.isBranch |=> !result.flagWrite)
    else $error("branch wrote flags");
  a_lsl_result: assert property (shf && instr.sop == SOP_SHIFT_LEFT_LOGICAL |=>
    result.rdValue == {$past(instr.rd[6:0]), 1'b0} &&
    result.flagsNew[FLAG_C] == $past(instr.rd[7])) else $error("shift left wrong");
  a_asr_sign: assert property (shf && instr.sop == SOP_SHIFT_RIGHT_ARITH |=>
    result.rdValue == {$past(instr.rd[7]), $past(instr.rd[7:1])}) else $error("asr wrong");
  a_swap_noflag: assert property (shf && instr.sop == SOP_SWAP_NIBBLES |=>
    result.rdWrite && !result.flagWrite) else $error("swap wrong");
  c_taken: cover property (result.pcLoad);
  c_refused: cover property (busy && instr.valid);
  c_swap: cover property (shf && instr.sop == SOP_SWAP_NIBBLES);
endmodule // bcs_checker
`default_nettype wire

// *** bcs_core_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// status register of the core around the unit; bench preload wins
module bcs_core_model
  import bcs_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire bcs_result_s result,
  input wire logic loadEn,
  input wire logic [7:0] loadVal,
  output logic [7:0] flags
);
  logic [7:0] flags_ff; // held status
  // write-back of shift flags, so a wrong flag shows on the next op too
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      flags_ff <= FLAGS_RESET;
    end else if (loadEn) begin
      flags_ff <= loadVal;
    end else if (result.flagWrite) begin
      flags_ff <= result.flagsNew;
    end
  end
  assign flags = flags_ff;
endmodule // bcs_core_model
`default_nettype wire

// *** test_branch_condition_and_shift_unit.sv ***
`timescale 1ns/1ps
`default_nettype none
module test_branch_condition_and_shift_unit;
  import bcs_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  bcs_instr_s instr = '0;
  logic loadEn = 1'b0;
  logic [7:0] loadVal = 8'h00;
  logic [7:0] flags;
  bcs_result_s result;
  logic busy;
  int fails = 0;
  int n_checks = 0;
  bcs_branch_shift bcs_branch_shift_i (.clk(clk), .rst(rst), .instr(instr),
    .flagsIn(flags), .result(result), .busy(busy));
  bcs_core_model bcs_core_model_i (.clk(clk), .rst(rst), .result(result),
    .loadEn(loadEn), .loadVal(loadVal), .flags(flags));
  always #2.5 clk = ~clk;
  task chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task conclude;
    $display("checks %0d fails %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task step;
    @(posedge clk);
    #1;
  endtask
  // preload flags, then hold one op valid over its taking edge
  task issue(input logic br, input int c, input logic [2:0] s, input logic [7:0] r,
    input logic [7:0] f);
    step;
    loadEn = 1'b1;
    loadVal = f;
    step;
    loadEn = 1'b0;
    instr = {1'b1, br, 4'(c), s, 7'h40, 16'hFFFE, r};
    step;
  endtask
  // every condition with its flag set and clear, plus the two undefined codes
  // that never branch; refused op in the discard cycle
  task automatic branch_all;
    int fb[16] = '{0, 0, 2, 2, 3, 3, 5, 5, 6, 6, 3, 3, 7, 7, 0, 0};
    logic [15:0] pol = 16'h1566;
    logic tk;
    for (int c = 0; c < 16; c++) begin
      for (int v = 0; v < 2; v++) begin
        issue(1'b1, c, SOP_SWAP_NIBBLES, 8'h5A, 8'(v) << fb[c]);
        tk = (c < 14) && (v == int'(pol[c]));
        chk("pcLoad", 16'(result.pcLoad), 16'(tk));
        chk("flagWrite", 16'(result.flagWrite), 16'h0000);
        if (tk) begin
          chk("pcTarget", result.pcTarget, 16'hFFBF);
          chk("busy", 16'(busy & result.flush), 16'h0001);
          instr.isBranch = 1'b0;
          step;
          instr.valid = 1'b0;
          chk("refused", 16'({result.rdWrite, result.pcLoad, busy}), 16'h0000);
        end else begin
          instr.valid = 1'b0;
          chk("busy idle", 16'({busy, result.flush}), 16'h0000);
        end
      end
    end
  endtask
  // each shift op from a carry-set status, a zero result, an undefined code
  task automatic shift_all;
    logic [2:0] op[8] = '{SOP_SHIFT_LEFT_LOGICAL, SOP_SHIFT_RIGHT_LOGICAL,
      SOP_ROTATE_LEFT_CARRY, SOP_ROTATE_RIGHT_CARRY, SOP_SHIFT_RIGHT_ARITH,
      SOP_SWAP_NIBBLES, SOP_SHIFT_LEFT_LOGICAL, 3'h6};
    logic [7:0] ra[8] = '{8'h96, 8'h96, 8'h96, 8'h96, 8'h96, 8'h96, 8'h80, 8'h96};
    logic [7:0] re[8] = '{8'h2C, 8'h4B, 8'h2D, 8'hCB, 8'hCB, 8'h69, 8'h00, 8'h96};
    logic [7:0] fe[8] = '{8'h19, 8'h00, 8'h19, 8'h0C, 8'h0C, 8'h01, 8'h1B, 8'h01};
    logic [7:0] fw = 8'h5F;
    for (int i = 0; i < 8; i++) begin
      issue(1'b0, 0, op[i], ra[i], 8'h01);
      instr.valid = 1'b0;
      chk("rdWrite", 16'(result.rdWrite), 16'h0001);
      chk("rdValue", 16'(result.rdValue), 16'(re[i]));
      chk("flagWrite", 16'(result.flagWrite), 16'(fw[i]));
      chk("flagsNew", 16'(result.flagsNew), 16'(fe[i]));
      step;
      chk("status", 16'(flags), 16'(fe[i]));
    end
  endtask
  initial begin
    repeat (3) @(posedge clk);
    #1;
    rst = 1'b0;
    branch_all;
    shift_all;
    conclude;
  end
  initial begin
    repeat (20000) @(posedge clk);
    fails++;
    conclude;
  end
endmodule // test_branch_condition_and_shift_unit
bind bcs_branch_shift bcs_checker bcs_checker_i (.clk(clk), .rst(rst), .instr(instr),
  .flagsIn(flagsIn), .result(result), .busy(busy));
`default_nettype wire
